// ===== hdl/sched_regs.svh
// constants for the list scheduler: widths, reset values and table offsets
`ifndef SCHED_REGS_SVH
`define SCHED_REGS_SVH
`define SCHED_PTR_W 32
`define SCHED_NULL_PTR 32'h0000_0000
`define SCHED_WEIGHT_W 2
`define SCHED_WEIGHT_RST 2'h0
`define SCHED_IDX_W 5
`define SCHED_IDX_PAD_W 25
`define SCHED_DWORD_PAD 2'h0
`define SCHED_TABLE_FIRST 32'h0000_0000
`define SCHED_TABLE_LAST 32'h0000_007C
`define SCHED_FLAG_RST 1'h0
`endif

// ===== hdl/sched_pkg.sv
// types shared by the list scheduler modules
package sched_pkg;
	typedef enum logic {
		NP_CTRL,
		NP_BULK
	} np_list_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PICK,
		ST_HEAD_RD,
		ST_PER_CHECK,
		ST_PER_WAIT,
		ST_NP_WAIT
	} sched_state_t;
endpackage : sched_pkg

// ===== hdl/sched_pending_flag.sv
// sticky pending flag: software sets, scheduler clears, set wins
`timescale 1ns/10ps
`include "sched_regs.svh"
module sched_pending_flag (
	input wire logic i_core_clk, // controller clock
	input wire logic i_nrst, // synchronous reset, active low
	input wire logic i_set, // software marks the list filled
	input wire logic i_clr, // scheduler consumed the flag
	output logic o_flag // current flag value
);
	// a set in the same cycle as the clear is kept
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			o_flag <= `SCHED_FLAG_RST;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clr) begin
			o_flag <= 1'b0;
		end
	end
endmodule : sched_pending_flag

// ===== hdl/sched_weight_ctr.sv
// counts control descriptors served against the control-to-bulk weight
`timescale 1ns/10ps
`include "sched_regs.svh"
module sched_weight_ctr (
	input wire logic i_core_clk, // controller clock
	input wire logic i_nrst, // synchronous reset, active low
	input wire logic [`SCHED_WEIGHT_W-1:0] i_weight, // weight minus one
	input wire logic i_served, // one control descriptor served
	input wire logic i_clear, // restart the count
	output logic o_last // next served descriptor meets the weight
);
	logic [`SCHED_WEIGHT_W-1:0] count_q;
	// served count minus one equals the weight on the final descriptor
	assign o_last = (count_q >= i_weight); // RL23
	// count up, wrap to zero once the weight is met
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			count_q <= `SCHED_WEIGHT_RST;
		end else if (i_clear || (i_served && o_last)) begin
			count_q <= `SCHED_WEIGHT_RST;
		end else if (i_served) begin
			count_q <= count_q + 2'h1;
		end
	end
endmodule : sched_weight_ctr

// ===== hdl/usb_host_list_scheduler.sv
// list scheduler: picks periodic, control or bulk list and walks descriptors
`timescale 1ns/10ps
`include "sched_regs.svh"

// How it works
// RL1: serve N control descriptors for each bulk descriptor, N from one to four.
// RL2: weighting ignores list length; a lone control descriptor is served N times. Here a control list end with no pending hands the turn to bulk early.
// RL3: an empty non-periodic list hands its turn straight to the other list.
// RL4: start processing with a one-hot list-active request to the fetcher.
// RL5: fetcher answers with iso, service-complete and list-empty indications.
// RL6: a disabled list is skipped and the next list is tried.
// RL7: enable changes take effect only at the next frame boundary.
// RL8: after re-enable only head and cursor pointers are trusted.
// RL9: an isochronous descriptor with iso not allowed ends the periodic walk.
// RL10: first service after entering running starts at head; zero head means empty.
// RL11: periodic head comes from the table indexed by low five frame bits.
// RL12: a non-zero cursor names the next non-periodic descriptor to serve.
// RL13: zero cursor: if pending, load head, clear pending, serve; else move on.
// RL14: periodic walk follows non-zero next pointers, then goes non-periodic.
// RL15: bulk serves exactly one descriptor and then hands to control.
// RL16: control serves until the weight count is reached, then hands to bulk.
// RL17: descriptors served in order from head; list end reloads the head.
// RL18: each descriptor gets one service, then the next descriptor follows.
// RL19: a late isochronous descriptor is retired by the fetcher within one service.
// RL20: past the periodic threshold periodic service wins until its list ends.
// RL21: interrupt descriptors precede isochronous ones on the periodic list.
// RL22: a descriptor counts as served only on the service-complete handshake.
// RL23: the weight is held as N minus one in two bits.
module usb_host_list_scheduler
	import sched_pkg::*;
(
	input wire logic i_core_clk, // controller clock, 20 MHz
	input wire logic i_nrst, // synchronous reset, active low
	input wire logic i_running_state, // controller is in the running state
	input wire logic i_ctrl_enable, // control list enable
	input wire logic i_bulk_enable, // bulk list enable
	input wire logic i_periodic_enable, // periodic list enable
	input wire logic i_iso_list_allow, // isochronous descriptors may be served
	input wire logic [1:0] i_ctrl_to_bulk_weight, // ratio minus one
	input wire logic i_frame_boundary, // one-cycle pulse at each frame start
	input wire logic [15:0] i_frame_index, // current frame number
	input wire logic i_periodic_due, // frame is past the periodic threshold
	input wire logic [31:0] i_periodic_head_table, // base of the periodic head table
	input wire logic [31:0] i_ctrl_first_desc_ptr, // control list head
	input wire logic [31:0] i_bulk_first_desc_ptr, // bulk list head
	input wire logic i_ctrl_fill_set, // pulse: software marks control filled
	input wire logic i_bulk_fill_set, // pulse: software marks bulk filled
	output logic o_head_rd_req, // request a table dword read
	output logic [31:0] o_head_rd_addr, // address of the table dword
	input wire logic i_head_rd_valid, // pulse: table dword returned
	input wire logic [31:0] i_head_rd_data, // returned periodic head pointer
	output logic o_ctrl_active, // control list active toward fetcher
	output logic o_bulk_active, // bulk list active toward fetcher
	output logic o_periodic_active, // periodic list active toward fetcher
	output logic [31:0] o_desc_ptr, // descriptor to fetch and serve
	input wire logic i_svc_complete, // pulse: descriptor service done
	input wire logic i_iso_desc, // served descriptor was isochronous
	input wire logic i_list_empty, // pulse: no descriptor at that pointer
	input wire logic [31:0] i_next_desc_ptr, // next pointer of served descriptor
	output logic [31:0] o_ctrl_cursor_ptr, // control cursor
	output logic [31:0] o_bulk_cursor_ptr, // bulk cursor
	output logic [31:0] o_periodic_cursor_ptr, // periodic descriptor in service
	output logic o_ctrl_pending_flag, // control list filled flag
	output logic o_bulk_pending_flag, // bulk list filled flag
	output logic o_periodic_done // periodic walk finished this frame
);
	sched_state_t state_q;
	np_list_t np_turn_q;
	logic ctrl_en_q, bulk_en_q, per_en_q;
	logic running_q;
	logic ctrl_first_q, bulk_first_q;
	logic ctrl_pending, bulk_pending;
	logic ctrl_last;
	logic ctrl_served, weight_clear;
	logic ctrl_clr, bulk_clr;
	logic np_is_ctrl;
	logic np_en, np_first, np_pend;
	logic [31:0] np_head, np_cursor, np_pick_ptr;
	logic np_go;

	// enables sampled only at frame boundaries
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			ctrl_en_q <= 1'b0;
			bulk_en_q <= 1'b0;
			per_en_q <= 1'b0;
		end else if (i_frame_boundary) begin
			ctrl_en_q <= i_ctrl_enable; // RL7
			bulk_en_q <= i_bulk_enable; // RL7
			per_en_q <= i_periodic_enable; // RL7
		end
	end

	// first-service marks, armed when the running state is entered
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			running_q <= 1'b0;
			ctrl_first_q <= 1'b0;
			bulk_first_q <= 1'b0;
		end else begin
			running_q <= i_running_state;
			if (i_running_state && !running_q) begin
				ctrl_first_q <= 1'b1; // RL10
				bulk_first_q <= 1'b1; // RL10
			end else if (state_q == ST_PICK && i_running_state && !per_turn && np_go) begin
				ctrl_first_q <= ctrl_first_q && !np_is_ctrl;
				bulk_first_q <= bulk_first_q && np_is_ctrl;
			end
		end
	end

	// selection of the non-periodic list whose turn it is
	always_comb begin
		np_is_ctrl = (np_turn_q == NP_CTRL);
		np_en = np_is_ctrl ? ctrl_en_q : bulk_en_q;
		np_first = np_is_ctrl ? ctrl_first_q : bulk_first_q;
		np_pend = np_is_ctrl ? ctrl_pending : bulk_pending;
		np_head = np_is_ctrl ? i_ctrl_first_desc_ptr : i_bulk_first_desc_ptr;
		np_cursor = np_is_ctrl ? o_ctrl_cursor_ptr : o_bulk_cursor_ptr;
		np_pick_ptr = `SCHED_NULL_PTR;
		np_go = 1'b0;
		if (!np_en) begin
			np_go = 1'b0; // RL6
		end else if (np_first) begin
			np_pick_ptr = np_head; // RL10
			np_go = 1'b1;
		end else if (np_cursor != `SCHED_NULL_PTR) begin
			np_pick_ptr = np_cursor; // RL12
			np_go = 1'b1;
		end else if (np_pend) begin
			np_pick_ptr = np_head; // RL13 RL17
			np_go = 1'b1;
		end
	end

	// periodic service wins once the threshold is passed
	logic per_turn;
	assign per_turn = i_periodic_due && !o_periodic_done; // RL20

	// pending flag consumed when the head is loaded from it
	assign ctrl_clr = (state_q == ST_PICK) && i_running_state && !per_turn && np_is_ctrl && np_go
		&& !ctrl_first_q && (o_ctrl_cursor_ptr == `SCHED_NULL_PTR); // RL13
	assign bulk_clr = (state_q == ST_PICK) && i_running_state && !per_turn && !np_is_ctrl && np_go
		&& !bulk_first_q && (o_bulk_cursor_ptr == `SCHED_NULL_PTR); // RL13

	// served control descriptors advance the weight count
	assign ctrl_served = (state_q == ST_NP_WAIT) && o_ctrl_active && i_svc_complete; // RL22
	assign weight_clear = (state_q == ST_NP_WAIT) && o_bulk_active
		&& (i_svc_complete || i_list_empty);

	sched_pending_flag u_ctrl_pending (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_set(i_ctrl_fill_set),
		.i_clr(ctrl_clr),
		.o_flag(ctrl_pending)
	);

	sched_pending_flag u_bulk_pending (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_set(i_bulk_fill_set),
		.i_clr(bulk_clr),
		.o_flag(bulk_pending)
	);

	sched_weight_ctr u_weight (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_weight(i_ctrl_to_bulk_weight),
		.i_served(ctrl_served),
		.i_clear(weight_clear),
		.o_last(ctrl_last)
	);

	// pending flags mirrored onto registered status outputs
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			o_ctrl_pending_flag <= `SCHED_FLAG_RST;
			o_bulk_pending_flag <= `SCHED_FLAG_RST;
		end else begin
			o_ctrl_pending_flag <= ctrl_pending;
			o_bulk_pending_flag <= bulk_pending;
		end
	end

	// main sequencer: list choice, fetcher handshake and cursor upkeep
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			np_turn_q <= NP_CTRL;
			o_head_rd_req <= 1'b0;
			o_head_rd_addr <= `SCHED_NULL_PTR;
			o_ctrl_active <= 1'b0;
			o_bulk_active <= 1'b0;
			o_periodic_active <= 1'b0;
			o_desc_ptr <= `SCHED_NULL_PTR;
			o_ctrl_cursor_ptr <= `SCHED_NULL_PTR;
			o_bulk_cursor_ptr <= `SCHED_NULL_PTR;
			o_periodic_cursor_ptr <= `SCHED_NULL_PTR;
			o_periodic_done <= 1'b0;
		end else begin
			if (i_frame_boundary) begin
				o_periodic_done <= 1'b0;
				o_periodic_cursor_ptr <= `SCHED_NULL_PTR; // RL8
			end
			case (state_q)
				ST_IDLE: begin
					if (i_running_state) begin
						state_q <= ST_PICK;
					end
				end
				ST_PICK: begin
					if (!i_running_state) begin
						state_q <= ST_IDLE;
					end else if (per_turn) begin
						if (per_en_q) begin
							o_head_rd_req <= 1'b1; // RL11
							o_head_rd_addr <= i_periodic_head_table
								+ {{`SCHED_IDX_PAD_W{1'b0}}, i_frame_index[`SCHED_IDX_W-1:0], `SCHED_DWORD_PAD}; // RL11
							state_q <= ST_HEAD_RD;
						end else begin
							o_periodic_done <= 1'b1; // RL6
						end
					end else if (np_go && np_pick_ptr != `SCHED_NULL_PTR) begin
						if (np_is_ctrl) begin
							o_ctrl_cursor_ptr <= np_pick_ptr; // RL13
							o_ctrl_active <= 1'b1; // RL4
						end else begin
							o_bulk_cursor_ptr <= np_pick_ptr; // RL13
							o_bulk_active <= 1'b1; // RL4
						end
						o_desc_ptr <= np_pick_ptr;
						state_q <= ST_NP_WAIT;
					end else begin
						// empty or disabled: hand the turn over at once
						np_turn_q <= np_is_ctrl ? NP_BULK : NP_CTRL; // RL3 RL6
					end
				end
				ST_HEAD_RD: begin
					if (i_head_rd_valid) begin
						o_head_rd_req <= 1'b0;
						o_periodic_cursor_ptr <= i_head_rd_data; // RL11
						state_q <= ST_PER_CHECK;
					end
				end
				ST_PER_CHECK: begin
					if (o_periodic_cursor_ptr == `SCHED_NULL_PTR || !per_en_q) begin
						o_periodic_done <= 1'b1; // RL10 RL7
						state_q <= ST_PICK;
					end else begin
						o_periodic_active <= 1'b1; // RL4
						o_desc_ptr <= o_periodic_cursor_ptr;
						state_q <= ST_PER_WAIT;
					end
				end
				ST_PER_WAIT: begin
					if (i_list_empty) begin
						o_periodic_active <= 1'b0; // RL5
						o_periodic_done <= 1'b1;
						state_q <= ST_PICK;
					end else if (i_svc_complete) begin
						// late iso retirement happens inside one fetcher service
						o_periodic_active <= 1'b0; // RL22 RL19
						if (i_iso_desc && !i_iso_list_allow) begin
							o_periodic_done <= 1'b1; // RL9 RL21
							state_q <= ST_PICK;
						end else begin
							o_periodic_cursor_ptr <= i_next_desc_ptr; // RL14 RL18
							state_q <= ST_PER_CHECK;
						end
					end
				end
				ST_NP_WAIT: begin
					if (i_list_empty) begin
						o_ctrl_active <= 1'b0;
						o_bulk_active <= 1'b0;
						if (o_ctrl_active) begin
							o_ctrl_cursor_ptr <= `SCHED_NULL_PTR;
						end else begin
							o_bulk_cursor_ptr <= `SCHED_NULL_PTR;
						end
						np_turn_q <= o_ctrl_active ? NP_BULK : NP_CTRL; // RL3
						state_q <= ST_PICK;
					end else if (i_svc_complete) begin
						o_ctrl_active <= 1'b0; // RL22
						o_bulk_active <= 1'b0;
						if (o_ctrl_active) begin
							o_ctrl_cursor_ptr <= i_next_desc_ptr; // RL17 RL18
							np_turn_q <= ctrl_last ? NP_BULK : NP_CTRL; // RL1 RL2 RL16
						end else begin
							o_bulk_cursor_ptr <= i_next_desc_ptr; // RL17 RL18
							np_turn_q <= NP_CTRL; // RL15
						end
						state_q <= ST_PICK;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// checks
	property p_one_hot_active;
		@(posedge i_core_clk) disable iff (!i_nrst)
		$onehot0({o_ctrl_active, o_bulk_active, o_periodic_active});
	endproperty
	a_one_hot_active: assert property (p_one_hot_active) else $error("more than one list active"); // RL4

	property p_bulk_then_ctrl;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(o_bulk_active && i_svc_complete) |=> (np_turn_q == NP_CTRL);
	endproperty
	a_bulk_then_ctrl: assert property (p_bulk_then_ctrl) else $error("bulk did not hand to control"); // RL15

	property p_weight_met;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(ctrl_served && ctrl_last) |=> (np_turn_q == NP_BULK);
	endproperty
	a_weight_met: assert property (p_weight_met) else $error("weight met but control kept turn"); // RL16

	property p_weight_not_met;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(ctrl_served && !ctrl_last) |=> (np_turn_q == NP_CTRL);
	endproperty
	a_weight_not_met: assert property (p_weight_not_met) else $error("control left before weight met"); // RL1

	property p_iso_stop;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(state_q == ST_PER_WAIT && i_svc_complete && !i_list_empty && i_iso_desc && !i_iso_list_allow)
			|=> (o_periodic_done && state_q == ST_PICK);
	endproperty
	a_iso_stop: assert property (p_iso_stop) else $error("periodic walk went on past iso"); // RL9

	property p_head_addr;
		@(posedge i_core_clk) disable iff (!i_nrst)
		$rose(o_head_rd_req) |-> (o_head_rd_addr - i_periodic_head_table) <= `SCHED_TABLE_LAST
			&& o_head_rd_addr[1:0] == 2'h0;
	endproperty
	a_head_addr: assert property (p_head_addr) else $error("periodic head address out of table"); // RL11

	property p_np_empty_switch;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(state_q == ST_NP_WAIT && i_list_empty && o_ctrl_active) |=> (np_turn_q == NP_BULK);
	endproperty
	a_np_empty_switch: assert property (p_np_empty_switch) else $error("empty control kept turn"); // RL3

	property p_active_holds;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(o_ctrl_active && !i_svc_complete && !i_list_empty) |=> o_ctrl_active && $stable(o_desc_ptr);
	endproperty
	a_active_holds: assert property (p_active_holds) else $error("active dropped without handshake"); // RL22

	property p_periodic_first;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(state_q == ST_PICK && i_running_state && per_turn) |=> !o_ctrl_active && !o_bulk_active;
	endproperty
	a_periodic_first: assert property (p_periodic_first) else $error("non-periodic served while periodic due"); // RL20

	property p_disabled_skip;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(state_q == ST_PICK && !per_turn && !np_en) |=> !o_ctrl_active && !o_bulk_active;
	endproperty
	a_disabled_skip: assert property (p_disabled_skip) else $error("disabled list served"); // RL6

	c_ctrl_served: cover property (@(posedge i_core_clk) disable iff (!i_nrst) ctrl_served && ctrl_last);
	c_bulk_served: cover property (@(posedge i_core_clk) disable iff (!i_nrst) o_bulk_active && i_svc_complete);
	c_periodic_walk: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
		state_q == ST_PER_WAIT && i_svc_complete ##1 state_q == ST_PER_CHECK);
	c_pending_reload: cover property (@(posedge i_core_clk) disable iff (!i_nrst) ctrl_clr);
endmodule : usb_host_list_scheduler

// ===== testbench/fetch_model.sv
// behavioural descriptor fetcher for the list scheduler
`timescale 1ns/10ps
module fetch_model (
	input wire logic i_core_clk, // controller clock
	input wire logic i_slow, // answer late when high
	input wire logic i_any_active, // some list is active
	input wire logic [31:0] i_desc_ptr, // descriptor asked for
	input wire logic i_head_rd_req, // table read request
	input wire logic [31:0] i_head_rd_addr, // table dword address
	output logic o_svc_complete, // service done pulse
	output logic o_iso_desc, // descriptor is isochronous
	output logic o_list_empty, // no descriptor pulse
	output logic [31:0] o_next_desc_ptr, // next pointer
	output logic o_head_rd_valid, // table data pulse
	output logic [31:0] o_head_rd_data // table data
);
	logic [3:0] wait_q;
	logic [31:0] junk_q;
	// quiet start; descriptors at 0x_Fxx answer with list empty
	initial begin
		wait_q = 4'h1;
		junk_q = 32'h5A5A_0F0F;
		o_svc_complete = 1'b0;
		o_list_empty = 1'b0;
		o_iso_desc = 1'b0;
		o_head_rd_valid = 1'b0;
		o_next_desc_ptr = 32'h0000_0000;
		o_head_rd_data = 32'h0000_0000;
	end
	// one service per active request after a lag; lines carry junk between answers
	always @(posedge i_core_clk) begin
		junk_q <= junk_q + 32'h0135_79BD;
		o_svc_complete <= 1'b0;
		o_list_empty <= 1'b0;
		o_iso_desc <= junk_q[0];
		o_next_desc_ptr <= ~junk_q;
		if (!i_any_active || o_svc_complete || o_list_empty) begin
			wait_q <= i_slow ? 4'h6 : 4'h1;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else if (i_desc_ptr[11:8] == 4'hF) begin
			o_list_empty <= 1'b1;
		end else begin
			o_svc_complete <= 1'b1;
			o_iso_desc <= i_desc_ptr[11];
			o_next_desc_ptr <= (i_desc_ptr[6:4] == 3'h7) ? 32'h0000_0000 : i_desc_ptr + 32'h0000_0010;
		end
	end
	// head table: index 0 empty, index 2 names a list-empty descriptor, index 31 starts at isochronous tail, others interrupt list
	always @(posedge i_core_clk) begin
		o_head_rd_valid <= i_head_rd_req && !o_head_rd_valid;
		o_head_rd_data <= ~junk_q;
		if (i_head_rd_req && !o_head_rd_valid) begin
			o_head_rd_data <= (i_head_rd_addr[6:2] == 5'h00) ? 32'h0000_0000 :
				(i_head_rd_addr[6:2] == 5'h02) ? 32'h0000_0F00 :
				(i_head_rd_addr[6:2] == 5'h1F) ? 32'h0000_0860 : 32'h0000_0500;
		end
	end
endmodule : fetch_model

// ===== testbench/tb_top.sv
// self-checking bench for the list scheduler with a behavioural fetcher
`timescale 1ns/10ps
module tb_top;
	logic clk, nrst, running, ctrl_en, bulk_en, per_en, iso_allow, fb, due, cfill, slow;
	logic [1:0] weight;
	logic [15:0] fidx;
	logic hreq, hvalid, ca, ba, pa, svc, iso, lempty, pdone, cpend;
	logic [31:0] hadr, dptr, nptr, hdata, ccur;
	logic [33:0] served[$];
	logic [31:0] per_q[$];
	logic [31:0] haddr[$];
	int failures = 0;
	int checked = 0;
	usb_host_list_scheduler DUT (.i_core_clk(clk), .i_nrst(nrst), .i_running_state(running),
		.i_ctrl_enable(ctrl_en), .i_bulk_enable(bulk_en), .i_periodic_enable(per_en),
		.i_iso_list_allow(iso_allow), .i_ctrl_to_bulk_weight(weight), .i_frame_boundary(fb),
		.i_frame_index(fidx), .i_periodic_due(due), .i_periodic_head_table(32'h0000_1000),
		.i_ctrl_first_desc_ptr(32'h0000_0100), .i_bulk_first_desc_ptr(32'h0000_0200),
		.i_ctrl_fill_set(cfill), .i_bulk_fill_set(1'b0), .o_head_rd_req(hreq), .o_head_rd_addr(hadr),
		.i_head_rd_valid(hvalid), .i_head_rd_data(hdata), .o_ctrl_active(ca), .o_bulk_active(ba),
		.o_periodic_active(pa), .o_desc_ptr(dptr), .i_svc_complete(svc), .i_iso_desc(iso),
		.i_list_empty(lempty), .i_next_desc_ptr(nptr), .o_ctrl_cursor_ptr(ccur),
		.o_bulk_cursor_ptr(), .o_periodic_cursor_ptr(), .o_ctrl_pending_flag(cpend),
		.o_bulk_pending_flag(), .o_periodic_done(pdone));
	fetch_model partner (.i_core_clk(clk), .i_slow(slow), .i_any_active(ca | ba | pa), .i_desc_ptr(dptr),
		.i_head_rd_req(hreq), .i_head_rd_addr(hadr), .o_svc_complete(svc), .o_iso_desc(iso),
		.o_list_empty(lempty), .o_next_desc_ptr(nptr), .o_head_rd_valid(hvalid), .o_head_rd_data(hdata));
	// clock at 20 MHz
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// record each served descriptor with its list and each table address read
	always @(posedge clk) begin
		if (svc) served.push_back({pa, ba, dptr});
		if (svc && pa) per_q.push_back(dptr);
		if (hvalid) haddr.push_back(hadr);
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : tick
	task chk(input string what, input logic [33:0] exp, input logic [33:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task close_out;
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task wait_n(input int n);
		int k;
		k = 0;
		while (served.size() < n && k < 3000) begin
			tick(1);
			k++;
		end
		chk("service count", 34'(n), 34'(served.size()));
	endtask : wait_n
	// reset for four cycles, one frame boundary latches the enables, then enter running
	task start(input logic [1:0] w, input logic ce, input logic be, input logic pe, input logic lag);
		nrst = 1'b0;
		running = 1'b0;
		weight = w;
		ctrl_en = ce;
		bulk_en = be;
		per_en = pe;
		slow = lag;
		tick(4);
		served.delete();
		nrst = 1'b1;
		fb = 1'b1;
		tick(1);
		fb = 1'b0;
		running = 1'b1;
		tick(1);
	endtask : start
	// one frame of periodic service from table index idx
	task frame(input logic [4:0] idx, input logic allow, input int n, input logic [31:0] last);
		int k;
		per_q.delete();
		haddr.delete();
		fidx = {11'h000, idx};
		iso_allow = allow;
		fb = 1'b1;
		tick(1);
		fb = 1'b0;
		k = 0;
		while (pdone !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		chk("periodic done", 34'h1, {33'h0, pdone});
		chk("periodic count", 34'(n), 34'(per_q.size()));
		chk("table address", {2'b00, 32'h0000_1000 + {25'h0, idx, 2'b00}}, {2'b00, haddr[0]});
		if (n > 0) chk("periodic tail", {2'b00, last}, {2'b00, per_q[n - 1]});
	endtask : frame
	// watchdog
	initial begin
		#2_000_000;
		failures++;
		close_out();
	end
	initial begin
		int w, k, j, c;
		logic [33:0] e;
		{clk, nrst, running, ctrl_en, bulk_en, per_en, iso_allow, fb, due, cfill, slow} = '0;
		weight = 2'h0;
		fidx = 16'h0000;
		// every weight from 1:1 to 4:1, one run with a slow fetcher
		for (w = 0; w < 4; w++) begin
			start(w[1:0], 1'b1, 1'b1, 1'b0, w == 2);
			wait_n(2 * (w + 2));
			for (k = 0; k < 2 * (w + 2); k++) begin
				j = k % (w + 2);
				c = k / (w + 2);
				e = (j <= w) ? {2'b00, 32'h0000_0100 + 32'(16 * (c * (w + 1) + j))} : {2'b01, 32'h0000_0200 + 32'(16 * c)};
				chk("service order", e, served[k]);
			end
		end
		// control list ran out: bulk takes every turn until it also ends
		wait_n(16);
		chk("bulk run", {2'b01, 32'h0000_0270}, served[15]);
		chk("control cursor", 34'h0, {2'b00, ccur});
		cfill = 1'b1;
		tick(1);
		cfill = 1'b0;
		wait_n(18);
		chk("reload head", {2'b00, 32'h0000_0100}, served[16]);
		chk("cursor walk", {2'b00, 32'h0000_0110}, served[17]);
		chk("pending cleared", 34'h0, {33'h0, cpend});
		// periodic enable mid-frame waits for the boundary; bulk disabled
		start(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		due = 1'b1;
		per_en = 1'b1;
		haddr.delete();
		wait_n(4);
		chk("early table read", 34'h0, 34'(haddr.size()));
		chk("control only", {2'b00, 32'h0000_0130}, served[3]);
		frame(5'h03, 1'b1, 8, 32'h0000_0570);
		frame(5'h1F, 1'b0, 1, 32'h0000_0860);
		frame(5'h00, 1'b1, 0, 32'h0000_0000);
		frame(5'h02, 1'b1, 0, 32'h0000_0000);
		frame(5'h1F, 1'b1, 2, 32'h0000_0870);
		k = served.size();
		wait_n(k + 1);
		chk("resume control", 34'h0, {served[k][33:32], 32'h0000_0000});
		close_out();
	end
endmodule : tb_top
